// ### irq_flag_bank_with_clear.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] flags set only by hardware events
// [R2] flag reads 1 from event until clear
// [R3] writing zero to clear leaves flag
// [R4] reserved bits read zero, written zero
// [R5] clear bit 2 drops serial receive flag
// [R6] clear bit 1 drops serial transmit flag
// [R7] clear bit 0 drops serial error flag
// [R8] capcmp flags at bits 0,4,16,20
// [R9] capcmp clear bits drop matching flags
// [R10] wakeup flag at bit 0, event sets
// [R11] clear bit 0 drops wakeup flag
// [R12] capture-reload flag at timer bit 5
// [R13] timer 6 bit 4, timer 5 bit 3
// [R14] timers 4,3,2 at bits 2,1,0
// [R15] timer clear bits 5..0 drop flags
// [R16] set beats simultaneous clear
// [R17] clear registers stateless, read zero
module irq_flag_bank_with_clear (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [irq_flag_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [irq_flag_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [irq_flag_pkg::DAT_W-1:0] wb_dat_i,
  output logic [irq_flag_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_b_rx_evt_i,
  input wire logic serial_b_tx_evt_i,
  input wire logic serial_b_err_evt_i,
  input wire logic [irq_flag_pkg::CC_W-1:0] capcmp_evt_i,
  input wire logic wake_evt_i,
  input wire logic [irq_flag_pkg::TMR_W-1:0] timer_evt_i,
  output logic irq_o
);
  irq_flag_pkg::bus_state_e state_ff;
  irq_flag_pkg::bus_state_e nxt_state;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [31:0] lane_mask;
  logic [31:0] wd;
  logic req;
  logic wr_hit;
  logic [irq_flag_pkg::SER_W-1:0] ser_set;
  logic [irq_flag_pkg::SER_W-1:0] ser_clr;
  logic [irq_flag_pkg::SER_W-1:0] ser_q;
  logic [irq_flag_pkg::CC_W-1:0] cc_clr;
  logic [irq_flag_pkg::CC_W-1:0] cc_q;
  logic wake_clr;
  logic wake_q;
  logic [irq_flag_pkg::TMR_W-1:0] tmr_clr;
  logic [irq_flag_pkg::TMR_W-1:0] tmr_q;
  logic [irq_flag_pkg::GRP_W-1:0] grp_evt;
  logic [irq_flag_pkg::GRP_W-1:0] grp_clr;
  logic [irq_flag_pkg::GRP_W-1:0] pend;
  logic [irq_flag_pkg::GRP_W-1:0] mask;
  logic mask_we;

  assign req = wb_cyc_i & wb_stb_i;
  assign lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wd = wb_dat_i & lane_mask;
  // writes act only on the ack edge, exactly once per bus cycle
  assign wr_hit = (state_ff == irq_flag_pkg::BUS_ACK) & req & wb_we_i;

  // bus handshake: one wait state, ack for a single cycle
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      irq_flag_pkg::BUS_IDLE: begin
        if (req) begin
          nxt_state = irq_flag_pkg::BUS_ACK;
        end
      end
      irq_flag_pkg::BUS_ACK: begin
        nxt_state = irq_flag_pkg::BUS_IDLE;
      end
      default: begin
        nxt_state = irq_flag_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= irq_flag_pkg::BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wb_ack_o = (state_ff == irq_flag_pkg::BUS_ACK);

  // read data captured when the request is taken
  always_comb begin
    nxt_rdat = rdat_ff;
    if ((state_ff == irq_flag_pkg::BUS_IDLE) && req) begin
      nxt_rdat = irq_flag_pkg::DATA_ZERO; // R4 R17
      if (!wb_we_i) begin
        case (wb_adr_i)
          irq_flag_pkg::REQ3_STAT_OFS: begin
            nxt_rdat[irq_flag_pkg::SER_RX_BIT] = ser_q[irq_flag_pkg::SER_RX_BIT];
            nxt_rdat[irq_flag_pkg::SER_TX_BIT] = ser_q[irq_flag_pkg::SER_TX_BIT];
            nxt_rdat[irq_flag_pkg::SER_ERR_BIT] = ser_q[irq_flag_pkg::SER_ERR_BIT];
          end
          irq_flag_pkg::REQ4_STAT_OFS: begin
            nxt_rdat[irq_flag_pkg::CC0_BIT] = cc_q[0]; // R8
            nxt_rdat[irq_flag_pkg::CC1_BIT] = cc_q[1]; // R8
            nxt_rdat[irq_flag_pkg::CC2_BIT] = cc_q[2]; // R8
            nxt_rdat[irq_flag_pkg::CC3_BIT] = cc_q[3]; // R8
          end
          irq_flag_pkg::REQ5_STAT_OFS: begin
            nxt_rdat[irq_flag_pkg::WAKE_BIT] = wake_q; // R10
          end
          irq_flag_pkg::TMR_STAT_OFS: begin
            // R12 R13 R14
            nxt_rdat[irq_flag_pkg::TMR_LSB +: irq_flag_pkg::TMR_W] = tmr_q;
          end
          irq_flag_pkg::PEND_OFS: begin
            nxt_rdat[irq_flag_pkg::GRP_W-1:0] = pend;
          end
          irq_flag_pkg::MASK_OFS: begin
            nxt_rdat[irq_flag_pkg::GRP_W-1:0] = mask;
          end
          // clear registers and unmapped addresses answer zero
          default: begin
            nxt_rdat = irq_flag_pkg::DATA_ZERO; // R17
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= irq_flag_pkg::DATA_ZERO;
    end else begin
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_dat_o = rdat_ff;

  // clear pulses are decoded from the bus, never stored
  always_comb begin
    ser_clr = irq_flag_pkg::SER_RST;
    cc_clr = irq_flag_pkg::CC_RST;
    wake_clr = irq_flag_pkg::WAKE_RST;
    tmr_clr = irq_flag_pkg::TMR_RST;
    grp_clr = irq_flag_pkg::GRP_RST;
    mask_we = 1'b0;
    if (wr_hit) begin
      case (wb_adr_i)
        irq_flag_pkg::REQ3_CLR_OFS: begin
          ser_clr[irq_flag_pkg::SER_RX_BIT] = wd[irq_flag_pkg::SER_RX_BIT]; // R5
          ser_clr[irq_flag_pkg::SER_TX_BIT] = wd[irq_flag_pkg::SER_TX_BIT]; // R6
          ser_clr[irq_flag_pkg::SER_ERR_BIT] = wd[irq_flag_pkg::SER_ERR_BIT]; // R7
        end
        irq_flag_pkg::REQ4_CLR_OFS: begin
          cc_clr[0] = wd[irq_flag_pkg::CC0_BIT]; // R9
          cc_clr[1] = wd[irq_flag_pkg::CC1_BIT]; // R9
          cc_clr[2] = wd[irq_flag_pkg::CC2_BIT]; // R9
          cc_clr[3] = wd[irq_flag_pkg::CC3_BIT]; // R9
        end
        irq_flag_pkg::REQ5_CLR_OFS: begin
          wake_clr = wd[irq_flag_pkg::WAKE_BIT]; // R11
        end
        irq_flag_pkg::TMR_CLR_OFS: begin
          tmr_clr = wd[irq_flag_pkg::TMR_LSB +: irq_flag_pkg::TMR_W]; // R15
        end
        irq_flag_pkg::PEND_OFS: begin
          grp_clr = wd[irq_flag_pkg::GRP_W-1:0];
        end
        irq_flag_pkg::MASK_OFS: begin
          mask_we = 1'b1;
        end
        // status registers are read only: writes there set nothing
        default: begin
          mask_we = 1'b0; // R1
        end
      endcase
    end
  end

  always_comb begin
    ser_set = irq_flag_pkg::SER_RST;
    ser_set[irq_flag_pkg::SER_RX_BIT] = serial_b_rx_evt_i;
    ser_set[irq_flag_pkg::SER_TX_BIT] = serial_b_tx_evt_i;
    ser_set[irq_flag_pkg::SER_ERR_BIT] = serial_b_err_evt_i;
  end

  // R1 R2 R3 R16: set only from events, held until a one is written
  sticky_flag #(.WIDTH(irq_flag_pkg::SER_W)) u_ser (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ser_set),
    .clr_i(ser_clr),
    .q_o(ser_q)
  );

  sticky_flag #(.WIDTH(irq_flag_pkg::CC_W)) u_cc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(capcmp_evt_i),
    .clr_i(cc_clr),
    .q_o(cc_q)
  );

  sticky_flag #(.WIDTH(1)) u_wake (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(wake_evt_i),
    .clr_i(wake_clr),
    .q_o(wake_q)
  );

  sticky_flag #(.WIDTH(irq_flag_pkg::TMR_W)) u_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(timer_evt_i),
    .clr_i(tmr_clr),
    .q_o(tmr_q)
  );

  always_comb begin
    grp_evt = irq_flag_pkg::GRP_RST;
    grp_evt[irq_flag_pkg::GRP_SER] = |ser_set;
    grp_evt[irq_flag_pkg::GRP_CC] = |capcmp_evt_i;
    grp_evt[irq_flag_pkg::GRP_WAKE] = wake_evt_i;
    grp_evt[irq_flag_pkg::GRP_TMR] = |timer_evt_i;
  end

  // summary pending is separate from the flags so clearing one does not hide others
  irq_summary u_sum (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .evt_i(grp_evt),
    .clr_i(grp_clr),
    .mask_we_i(mask_we),
    .mask_d_i(wd[irq_flag_pkg::GRP_W-1:0]),
    .pend_o(pend),
    .mask_o(mask),
    .irq_o(irq_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic rd_ack;
  assign rd_ack = wb_ack_o & req & !wb_we_i;

  AST_ACK_ONE_WAIT: assert property ( // bus handshake, not a listed rule
    req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not given for one cycle after one wait");

  AST_ONLY_HW_SETS: assert property ( // R1
    $rose(ser_q[irq_flag_pkg::SER_RX_BIT]) |-> $past(serial_b_rx_evt_i))
    else $error("receive flag rose without its event");

  AST_TMR_ONLY_HW: assert property ( // R1
    $rose(tmr_q[5]) |-> $past(timer_evt_i[5]))
    else $error("capture-reload flag rose without its event");

  AST_FLAG_STICKS: assert property ( // R2
    cc_q[2] && !cc_clr[2] |=> cc_q[2])
    else $error("capcmp flag dropped without a clear");

  AST_EVENT_SETS: assert property ( // R2
    capcmp_evt_i[1] |=> cc_q[1])
    else $error("capcmp event did not set its flag");

  AST_ZERO_WRITE_KEEPS: assert property ( // R3
    wr_hit && wb_adr_i == irq_flag_pkg::TMR_CLR_OFS && wb_dat_i == 32'h00000000
    |=> tmr_q == ($past(tmr_q) | $past(timer_evt_i)))
    else $error("zero write to timer clear changed a flag");

  AST_RSV_ZERO: assert property ( // R4
    rd_ack && $past(wb_adr_i) == irq_flag_pkg::REQ3_STAT_OFS |-> wb_dat_o[31:3] == 29'h00000000)
    else $error("reserved bits of request three read nonzero");

  AST_RX_CLEAR: assert property ( // R5
    ser_clr[irq_flag_pkg::SER_RX_BIT] && !serial_b_rx_evt_i |=> !ser_q[irq_flag_pkg::SER_RX_BIT])
    else $error("receive flag survived its clear");

  AST_TX_CLEAR: assert property ( // R6
    wr_hit && wb_adr_i == irq_flag_pkg::REQ3_CLR_OFS && wb_sel_i[0] && wb_dat_i[1] && !serial_b_tx_evt_i
    |=> !ser_q[irq_flag_pkg::SER_TX_BIT])
    else $error("transmit flag survived its clear");

  AST_ERR_CLEAR: assert property ( // R7
    wr_hit && wb_adr_i == irq_flag_pkg::REQ3_CLR_OFS && wb_sel_i[0] && wb_dat_i[0] && !serial_b_err_evt_i
    |=> !ser_q[irq_flag_pkg::SER_ERR_BIT])
    else $error("error flag survived its clear");

  AST_CC_READ_MAP: assert property ( // R8
    rd_ack && $past(wb_adr_i) == irq_flag_pkg::REQ4_STAT_OFS
    |-> wb_dat_o == {11'h000, $past(cc_q[3]), 3'h0, $past(cc_q[2]), 11'h000, $past(cc_q[1]), 3'h0, $past(cc_q[0])})
    else $error("capcmp flags read at wrong positions");

  AST_CC_CLEAR: assert property ( // R9
    wr_hit && wb_adr_i == irq_flag_pkg::REQ4_CLR_OFS && wb_sel_i[2] && wb_dat_i[16] && !capcmp_evt_i[2]
    |=> !cc_q[2])
    else $error("capcmp bit 16 survived its clear");

  AST_WAKE_READ: assert property ( // R10
    rd_ack && $past(wb_adr_i) == irq_flag_pkg::REQ5_STAT_OFS |-> wb_dat_o == {31'h00000000, $past(wake_q)})
    else $error("wake register read wrong");

  AST_WAKE_CLEAR: assert property ( // R11
    wake_clr && !wake_evt_i |=> !wake_q)
    else $error("wake flag survived its clear");

  AST_TMR_READ: assert property ( // R12 R13 R14
    rd_ack && $past(wb_adr_i) == irq_flag_pkg::TMR_STAT_OFS |-> wb_dat_o == {26'h0000000, $past(tmr_q)})
    else $error("timer flags read at wrong positions");

  AST_TMR_CLEAR: assert property ( // R15
    wr_hit && wb_adr_i == irq_flag_pkg::TMR_CLR_OFS && wb_sel_i[0]
    |=> (tmr_q & $past(wb_dat_i[5:0]) & ~$past(timer_evt_i)) == 6'h00)
    else $error("timer flag survived its clear");

  AST_SET_WINS: assert property ( // R16
    wake_clr && wake_evt_i |=> wake_q)
    else $error("event lost against a clear");

  AST_SET_WINS_TMR: assert property ( // R16
    tmr_clr[5] && timer_evt_i[5] |=> tmr_q[5])
    else $error("capture-reload event lost against a clear");

  AST_CLR_READS_ZERO: assert property ( // R17
    rd_ack && $past(wb_adr_i) == irq_flag_pkg::REQ4_CLR_OFS |-> wb_dat_o == 32'h00000000)
    else $error("clear register read nonzero");

  AST_IRQ_LEVEL: assert property (
    (grp_evt & mask) != 4'h0 && !mask_we |=> irq_o)
    else $error("unmasked event did not raise the interrupt");

  COV_CLEAR_RX: cover property (ser_q[2] ##1 ser_clr[2] ##1 !ser_q[2]);
  COV_SET_CLEAR_SAME: cover property (tmr_clr[0] && timer_evt_i[0]);
  COV_IRQ_RAISE: cover property (!irq_o ##1 irq_o);
  COV_CC_READ: cover property (rd_ack && wb_dat_o[20]);
endmodule

// ### irq_flag_pkg.sv
package irq_flag_pkg;
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  // register byte offsets
  localparam logic [11:0] REQ3_STAT_OFS = 12'h010;
  localparam logic [11:0] REQ4_STAT_OFS = 12'h014;
  localparam logic [11:0] REQ5_STAT_OFS = 12'h020;
  localparam logic [11:0] TMR_STAT_OFS = 12'h160;
  localparam logic [11:0] TMR_CLR_OFS = 12'h180;
  localparam logic [11:0] REQ3_CLR_OFS = 12'h194;
  localparam logic [11:0] REQ4_CLR_OFS = 12'h198;
  localparam logic [11:0] REQ5_CLR_OFS = 12'h19C;
  localparam logic [11:0] PEND_OFS = 12'h1A0;
  localparam logic [11:0] MASK_OFS = 12'h1A4;

  // second serial channel flags in request register three
  localparam int SER_W = 3;
  localparam int SER_ERR_BIT = 0;
  localparam int SER_TX_BIT = 1;
  localparam int SER_RX_BIT = 2;

  // capture/compare service requests in request register four
  localparam int CC_W = 4;
  localparam int CC0_BIT = 0;
  localparam int CC1_BIT = 4;
  localparam int CC2_BIT = 16;
  localparam int CC3_BIT = 20;

  // wakeup flag in request register five
  localparam int WAKE_BIT = 0;

  // timer flags: t2, t3, t4, t5, t6, capture-reload from bit 0 up
  localparam int TMR_W = 6;
  localparam int TMR_LSB = 0;

  // summary pending and mask layout
  localparam int GRP_W = 4;
  localparam int GRP_SER = 0;
  localparam int GRP_CC = 1;
  localparam int GRP_WAKE = 2;
  localparam int GRP_TMR = 3;

  // reset values
  localparam logic [SER_W-1:0] SER_RST = 3'h0;
  localparam logic [CC_W-1:0] CC_RST = 4'h0;
  localparam logic WAKE_RST = 1'h0;
  localparam logic [TMR_W-1:0] TMR_RST = 6'h0;
  localparam logic [GRP_W-1:0] GRP_RST = 4'h0;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;
endpackage

// ### sticky_flag.sv
`timescale 1ns/1ps
module sticky_flag #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] q_ff;
  logic [WIDTH-1:0] nxt_q;

  // set wins so an event landing on a clear is kept
  always_comb begin
    nxt_q = set_i | (q_ff & ~clr_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule

// ### irq_summary.sv
`timescale 1ns/1ps
module irq_summary (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [irq_flag_pkg::GRP_W-1:0] evt_i,
  input wire logic [irq_flag_pkg::GRP_W-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [irq_flag_pkg::GRP_W-1:0] mask_d_i,
  output logic [irq_flag_pkg::GRP_W-1:0] pend_o,
  output logic [irq_flag_pkg::GRP_W-1:0] mask_o,
  output logic irq_o
);
  logic [irq_flag_pkg::GRP_W-1:0] mask_ff;
  logic [irq_flag_pkg::GRP_W-1:0] nxt_mask;

  sticky_flag #(.WIDTH(irq_flag_pkg::GRP_W)) u_pend (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(evt_i),
    .clr_i(clr_i),
    .q_o(pend_o)
  );

  always_comb begin
    nxt_mask = mask_we_i ? mask_d_i : mask_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_ff <= irq_flag_pkg::GRP_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  assign mask_o = mask_ff;
  assign irq_o = |(pend_o & mask_ff);
endmodule

// ### peripheral_evt_model.sv
`timescale 1ns/1ps
// stands in for serial, capture/compare, wakeup and timer units
module peripheral_evt_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [13:0] fire_i,
  output logic serial_b_err_evt_o,
  output logic serial_b_tx_evt_o,
  output logic serial_b_rx_evt_o,
  output logic [3:0] capcmp_evt_o,
  output logic wake_evt_o,
  output logic [5:0] timer_evt_o
);
  logic [13:0] evt_ff;
  logic [13:0] nxt_evt;
  // registered so events move just after the edge, like real unit logic
  always_comb begin
    nxt_evt = rst_i ? 14'h0000 : fire_i;
  end
  always_ff @(posedge clk_i) begin
    evt_ff <= nxt_evt;
  end
  // a fire_i held one cycle gives a one-cycle event, as used for the set/clear collision
  assign serial_b_err_evt_o = evt_ff[0];
  assign serial_b_tx_evt_o = evt_ff[1];
  assign serial_b_rx_evt_o = evt_ff[2];
  assign capcmp_evt_o = evt_ff[6:3];
  assign wake_evt_o = evt_ff[7];
  assign timer_evt_o = evt_ff[13:8];
endmodule

// ### irq_flag_bank_with_clear_tb_top.sv
`timescale 1ns/1ps
module irq_flag_bank_with_clear_tb_top;
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we;
  logic [11:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack, irq, s_rx, s_tx, s_err, wake;
  logic [3:0] cc;
  logic [5:0] tmr;
  logic [13:0] fire;
  int error_cnt, n_tests;
  logic [11:0] st_ofs [4];
  logic [11:0] clr_ofs [4];
  logic [31:0] full [4];
  logic [31:0] cur;

  irq_flag_bank_with_clear u_irq_flag_bank_with_clear (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .serial_b_rx_evt_i(s_rx), .serial_b_tx_evt_i(s_tx), .serial_b_err_evt_i(s_err),
    .capcmp_evt_i(cc), .wake_evt_i(wake), .timer_evt_i(tmr), .irq_o(irq));

  peripheral_evt_model u_peripheral_evt_model (
    .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .serial_b_err_evt_o(s_err), .serial_b_tx_evt_o(s_tx),
    .serial_b_rx_evt_o(s_rx), .capcmp_evt_o(cc), .wake_evt_o(wake), .timer_evt_o(tmr));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // no cycle count assumed: wait for ack, bounded
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    // a hung bus ends the run here, nothing after it
    if (wb_ack !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: ack timeout got %h exp %h", $time, wb_ack, 1'b1);
      close_out();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask

  task automatic pulse(input logic [13:0] v);
    @(posedge clk_i);
    fire <= v;
    @(posedge clk_i);
    fire <= 14'h0000;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  initial begin
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 12'h000;
    wb_sel = 4'hF;
    wb_dat_w = 32'h00000000;
    fire = 14'h0000;
    error_cnt = 0;
    n_tests = 0;
    st_ofs = '{irq_flag_pkg::REQ3_STAT_OFS, irq_flag_pkg::REQ4_STAT_OFS,
               irq_flag_pkg::REQ5_STAT_OFS, irq_flag_pkg::TMR_STAT_OFS};
    clr_ofs = '{irq_flag_pkg::REQ3_CLR_OFS, irq_flag_pkg::REQ4_CLR_OFS,
                irq_flag_pkg::REQ5_CLR_OFS, irq_flag_pkg::TMR_CLR_OFS};
    full[0] = (32'h1 << irq_flag_pkg::SER_RX_BIT) | (32'h1 << irq_flag_pkg::SER_TX_BIT)
              | (32'h1 << irq_flag_pkg::SER_ERR_BIT);
    full[1] = (32'h1 << irq_flag_pkg::CC0_BIT) | (32'h1 << irq_flag_pkg::CC1_BIT)
              | (32'h1 << irq_flag_pkg::CC2_BIT) | (32'h1 << irq_flag_pkg::CC3_BIT);
    full[2] = 32'h1 << irq_flag_pkg::WAKE_BIT;
    full[3] = ((32'h1 << irq_flag_pkg::TMR_W) - 32'h1) << irq_flag_pkg::TMR_LSB;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int g = 0; g < 4; g++) begin
      rd(st_ofs[g], 32'h00000000);
      rd(clr_ofs[g], 32'h00000000);
    end
    rd(irq_flag_pkg::PEND_OFS, 32'h00000000);
    rd(irq_flag_pkg::MASK_OFS, 32'h00000000);
    irq_chk(1'b0);
    // status registers must not take software writes
    for (int g = 0; g < 4; g++) begin
      wr(st_ofs[g], full[g]);
      rd(st_ofs[g], 32'h00000000);
    end
    wr(12'h7F0, 32'hFFFFFFFF);
    rd(12'h7F0, 32'h00000000);
    pulse(14'h3FFF);
    for (int g = 0; g < 4; g++) begin
      rd(st_ofs[g], full[g]);
      wr(clr_ofs[g], 32'h00000000);
      rd(st_ofs[g], full[g]);
      rd(clr_ofs[g], 32'h00000000);
    end
    rd(irq_flag_pkg::PEND_OFS, 32'h0000000F);
    // deselected byte lane must not clear anything
    wb_sel <= 4'hE;
    wr(irq_flag_pkg::REQ3_CLR_OFS, full[0]);
    rd(irq_flag_pkg::REQ3_STAT_OFS, full[0]);
    wb_sel <= 4'hF;
    irq_chk(1'b0);
    // drop one flag at a time, the others must stay
    for (int g = 0; g < 4; g++) begin
      cur = full[g];
      for (int b = 0; b < 32; b++) begin
        if (full[g][b]) begin
          wr(clr_ofs[g], 32'h1 << b);
          cur[b] = 1'b0;
          rd(st_ofs[g], cur);
        end
      end
    end
    // one-cycle event lands exactly on the clear edge and must survive it
    fork
      wr(irq_flag_pkg::TMR_CLR_OFS, full[3]);
      pulse(14'h3F00);
    join
    rd(irq_flag_pkg::TMR_STAT_OFS, full[3]);
    wr(irq_flag_pkg::TMR_CLR_OFS, full[3]);
    rd(irq_flag_pkg::TMR_STAT_OFS, 32'h00000000);
    // summary interrupt: raise, mask, clear
    wr(irq_flag_pkg::PEND_OFS, 32'h0000000F);
    rd(irq_flag_pkg::PEND_OFS, 32'h00000000);
    wr(irq_flag_pkg::MASK_OFS, 32'h0000000F);
    rd(irq_flag_pkg::MASK_OFS, 32'h0000000F);
    irq_chk(1'b0);
    pulse(14'h0080);
    irq_chk(1'b1);
    wr(irq_flag_pkg::MASK_OFS, 32'h00000000);
    irq_chk(1'b0);
    rd(irq_flag_pkg::PEND_OFS, 32'h1 << irq_flag_pkg::GRP_WAKE);
    wr(irq_flag_pkg::MASK_OFS, 32'h0000000F);
    irq_chk(1'b1);
    wr(irq_flag_pkg::PEND_OFS, 32'h1 << irq_flag_pkg::GRP_WAKE);
    irq_chk(1'b0);
    rd(irq_flag_pkg::REQ5_STAT_OFS, full[2]);
    // reset in mid-run clears everything
    pulse(14'h3FFF);
    do_reset();
    for (int g = 0; g < 4; g++) begin
      rd(st_ofs[g], 32'h00000000);
    end
    rd(irq_flag_pkg::MASK_OFS, 32'h00000000);
    rd(irq_flag_pkg::PEND_OFS, 32'h00000000);
    irq_chk(1'b0);
    close_out();
  end
endmodule
